/* File: verilog/lcd_command_decoder.sv */
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module lcd_command_decoder
  import lcd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  output logic copy_req,
  input wire logic [6:0] pin_column_count,
  input wire logic [7:0] cg_char_code,
  input wire logic [2:0] cg_line,
  output logic [15:0] cg_addr,
  output logic cg_from_rom,
  input wire logic [6:0] row_index,
  output logic [15:0] text_row_start,
  output logic [15:0] text_row_end,
  output logic [15:0] graphic_row_start,
  output logic [15:0] graphic_row_end,
  output logic [6:0] cursor_column,
  output logic [3:0] cursor_screen_row,
  output logic cursor_lower_half
);

  typedef enum {ST_IDLE, ST_RD_WAIT, ST_RD_TAKE, ST_WR_DONE} lcd_state_t;

  // Configuration pins are static straps, but still cross through two flops.
  logic [6:0] cols_meta;
  logic [6:0] cols_sync;

  // Bus slave state.
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic req;
  logic done;
  logic sel_op;
  logic sel_cmd;
  logic stall;

  // Programmed values.
  logic [7:0] operand_prev;
  logic [7:0] operand_last;
  logic [1:0] operand_count;
  logic [6:0] cursor_col;
  logic [4:0] cursor_row;
  logic [4:0] cg_offset;
  logic [15:0] display_ram_pointer;
  logic [15:0] text_base;
  logic [7:0] text_row_width;
  logic [15:0] graphic_base;
  logic [7:0] graphic_row_width;
  logic dual_scan;
  logic cg_external;
  logic peek_error;
  logic [7:0] read_data;
  logic [7:0] next_operand_prev;
  logic [7:0] next_operand_last;
  logic [1:0] next_operand_count;
  logic [6:0] next_cursor_col;
  logic [4:0] next_cursor_row;
  logic [4:0] next_cg_offset;
  logic [15:0] next_display_ram_pointer;
  logic [15:0] next_text_base;
  logic [7:0] next_text_row_width;
  logic [15:0] next_graphic_base;
  logic [7:0] next_graphic_row_width;
  logic next_dual_scan;
  logic next_cg_external;
  logic next_peek_error;
  logic [7:0] next_read_data;

  // Execution state.
  lcd_state_t state;
  lcd_state_t next_state;
  lcd_step_t pend_step;
  lcd_step_t next_pend_step;
  logic pend_bit;
  logic next_pend_bit;
  logic [7:0] next_mem_wdata;
  logic [15:0] next_mem_addr;
  logic next_mem_we;
  logic next_mem_re;
  logic next_copy_req;
  logic [15:0] next_cg_addr;
  logic next_cg_from_rom;

  // Decoder outputs.
  lcd_op_t dec_op;
  lcd_step_t dec_step;
  logic dec_bit_value;
  logic [2:0] dec_bit_index;
  logic dec_cg_external;
  logic [7:0] first_operand;
  logic [7:0] second_operand;
  logic [7:0] bit_byte;
  logic bit_value_q;
  logic [2:0] bit_index_q;
  logic next_bit_value;
  logic [2:0] next_bit_index;

  function automatic logic [15:0] step_ptr(input logic [15:0] p, input lcd_step_t s);
    unique case (s)
      STEP_INC: step_ptr = p + 16'h0001;
      STEP_DEC: step_ptr = p - 16'h0001;
      STEP_HOLD: step_ptr = p;
    endcase
  endfunction

  // The graphic area spans a whole screen of rows at the programmed width.
  function automatic logic in_graphic_area(input logic [15:0] p, input logic [15:0] base,
                                           input logic [7:0] width);
    logic [15:0] span;
    logic [15:0] rel;
    span = width * GFX_LINES;
    rel = p - base;
    in_graphic_area = rel < span;
  endfunction

  lcd_op_decode u_decode (
    .opcode(avs_writedata[7:0]),
    .op(dec_op),
    .step(dec_step),
    .bit_value(dec_bit_value),
    .bit_index(dec_bit_index),
    .cg_external(dec_cg_external)
  );

  lcd_row_addr u_text_rows (
    .clk(clk),
    .resetn(resetn),
    .base(text_base),
    .width(text_row_width),
    .row_index(row_index),
    .span(cols_sync),
    .row_start(text_row_start),
    .row_end(text_row_end)
  );

  lcd_row_addr u_graphic_rows (
    .clk(clk),
    .resetn(resetn),
    .base(graphic_base),
    .width(graphic_row_width),
    .row_index(row_index),
    .span(cols_sync),
    .row_start(graphic_row_start),
    .row_end(graphic_row_end)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cols_meta <= 7'h00;
      cols_sync <= 7'h00;
    end else begin
      cols_meta <= pin_column_count;
      cols_sync <= cols_meta;
    end
  end

  // Bus slave: one wait state, longer for operand and command writes while a command is still executing.
  always_comb begin
    req = avs_read | avs_write;
    done = req & ~avs_waitrequest;
    sel_op = avs_address == REG_OPERAND;
    sel_cmd = avs_address == REG_COMMAND;
    stall = avs_write & (sel_op | sel_cmd) & (state != ST_IDLE);
    next_waitrequest = 1'b1;
    if (req && avs_waitrequest && !stall) begin
      next_waitrequest = 1'b0;
    end
    next_readdata = avs_readdata;
    if (req && avs_waitrequest) begin
      next_readdata = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          REG_STATUS: begin
            next_readdata[CMD_READY_POS] = state == ST_IDLE;
            next_readdata[DATA_READY_POS] = state == ST_IDLE;
            next_readdata[PEEK_ERROR_POS] = peek_error;
          end
          REG_READ_DATA: next_readdata[7:0] = read_data;
          REG_CURSOR: begin
            next_readdata[COL_BITS-1:0] = cursor_col;
            next_readdata[CURSOR_ROW_POS +: ROW_BITS] = cursor_row;
          end
          REG_CG_OFFSET: next_readdata[CG_OFFSET_BITS-1:0] = cg_offset;
          REG_POINTER: next_readdata[15:0] = display_ram_pointer;
          REG_TEXT_BASE: next_readdata[15:0] = text_base;
          REG_TEXT_WIDTH: next_readdata[7:0] = text_row_width;
          REG_GFX_BASE: next_readdata[15:0] = graphic_base;
          REG_GFX_WIDTH: next_readdata[7:0] = graphic_row_width;
          REG_CONFIG: begin
            next_readdata[CFG_DUAL_SCAN_POS] = dual_scan;
            next_readdata[CFG_EXT_CG_POS] = cg_external;
          end
          default: next_readdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // With one operand pending it serves as the first operand.
  always_comb begin
    first_operand = (operand_count == 2'd2) ? operand_prev : operand_last;
    second_operand = operand_last;
    bit_byte = mem_rdata;
    bit_byte[bit_index_q] = bit_value_q;
  end

  // Command interpretation and the display RAM sequence.
  always_comb begin
    next_operand_prev = operand_prev;
    next_operand_last = operand_last;
    next_operand_count = operand_count;
    next_cursor_col = cursor_col;
    next_cursor_row = cursor_row;
    next_cg_offset = cg_offset;
    next_display_ram_pointer = display_ram_pointer;
    next_text_base = text_base;
    next_text_row_width = text_row_width;
    next_graphic_base = graphic_base;
    next_graphic_row_width = graphic_row_width;
    next_dual_scan = dual_scan;
    next_cg_external = cg_external;
    next_peek_error = peek_error;
    next_read_data = read_data;
    next_state = state;
    next_pend_step = pend_step;
    next_pend_bit = pend_bit;
    next_bit_value = bit_value_q;
    next_bit_index = bit_index_q;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_we = 1'b0;
    next_mem_re = 1'b0;
    next_copy_req = 1'b0;
    if (done && avs_write && avs_byteenable[0]) begin
      if (avs_address == REG_CONFIG) begin
        next_dual_scan = avs_writedata[CFG_DUAL_SCAN_POS];
        next_cg_external = avs_writedata[CFG_EXT_CG_POS];
      end
      if (sel_op) begin
        next_operand_prev = operand_last;
        next_operand_last = avs_writedata[7:0];
        next_operand_count = (operand_count == 2'd2) ? 2'd2 : operand_count + 2'd1;
      end
      if (sel_cmd) begin
        next_operand_count = 2'd0;
        next_pend_step = dec_step;
        next_pend_bit = 1'b0;
        next_bit_value = dec_bit_value;
        next_bit_index = dec_bit_index;
        unique case (dec_op)
          OP_CURSOR: begin
            next_cursor_col = first_operand[COL_BITS-1:0];
            next_cursor_row = second_operand[ROW_BITS-1:0];
          end
          OP_OFFSET: next_cg_offset = first_operand[CG_OFFSET_BITS-1:0];
          OP_POINTER: next_display_ram_pointer = {second_operand, first_operand};
          OP_TEXT_BASE: next_text_base = {second_operand, first_operand};
          OP_TEXT_WIDTH: next_text_row_width = first_operand;
          OP_GFX_BASE: next_graphic_base = {second_operand, first_operand};
          OP_GFX_WIDTH: next_graphic_row_width = first_operand;
          OP_CG_MODE: next_cg_external = dec_cg_external;
          OP_WRITE: begin
            next_mem_addr = display_ram_pointer;
            next_mem_wdata = first_operand;
            next_mem_we = 1'b1;
            next_state = ST_WR_DONE;
          end
          OP_READ: begin
            next_mem_addr = display_ram_pointer;
            next_mem_re = 1'b1;
            next_state = ST_RD_WAIT;
          end
          OP_PEEK: begin
            next_pend_step = STEP_HOLD;
            if (in_graphic_area(display_ram_pointer, graphic_base, graphic_row_width)) begin
              next_peek_error = 1'b0;
              next_mem_addr = display_ram_pointer;
              next_mem_re = 1'b1;
              next_state = ST_RD_WAIT;
            end else begin
              next_peek_error = 1'b1;
            end
          end
          OP_COPY: begin
            next_peek_error = 1'b0;
            next_copy_req = 1'b1;
          end
          OP_BIT: begin
            next_pend_step = STEP_HOLD;
            next_pend_bit = 1'b1;
            next_mem_addr = display_ram_pointer;
            next_mem_re = 1'b1;
            next_state = ST_RD_WAIT;
          end
          OP_NONE: next_state = ST_IDLE;
        endcase
      end
    end
    unique case (state)
      ST_IDLE: ;
      ST_RD_WAIT: next_state = ST_RD_TAKE;
      ST_RD_TAKE: begin
        if (pend_bit) begin
          next_mem_wdata = bit_byte;
          next_mem_we = 1'b1;
          next_state = ST_WR_DONE;
        end else begin
          next_read_data = mem_rdata;
          next_display_ram_pointer = step_ptr(display_ram_pointer, pend_step);
          next_state = ST_IDLE;
        end
      end
      ST_WR_DONE: begin
        next_display_ram_pointer = step_ptr(display_ram_pointer, pend_step);
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      operand_prev <= BYTE_RST;
      operand_last <= BYTE_RST;
      operand_count <= 2'd0;
      cursor_col <= 7'h00;
      cursor_row <= 5'h00;
      cg_offset <= 5'h00;
      display_ram_pointer <= ADDR_RST;
      text_base <= ADDR_RST;
      text_row_width <= BYTE_RST;
      graphic_base <= ADDR_RST;
      graphic_row_width <= BYTE_RST;
      dual_scan <= 1'b0;
      cg_external <= 1'b0;
      peek_error <= 1'b0;
      read_data <= BYTE_RST;
      state <= ST_IDLE;
      pend_step <= STEP_HOLD;
      pend_bit <= 1'b0;
      bit_value_q <= 1'b0;
      bit_index_q <= 3'd0;
      mem_addr <= ADDR_RST;
      mem_wdata <= BYTE_RST;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      copy_req <= 1'b0;
    end else begin
      operand_prev <= next_operand_prev;
      operand_last <= next_operand_last;
      operand_count <= next_operand_count;
      cursor_col <= next_cursor_col;
      cursor_row <= next_cursor_row;
      cg_offset <= next_cg_offset;
      display_ram_pointer <= next_display_ram_pointer;
      text_base <= next_text_base;
      text_row_width <= next_text_row_width;
      graphic_base <= next_graphic_base;
      graphic_row_width <= next_graphic_row_width;
      dual_scan <= next_dual_scan;
      cg_external <= next_cg_external;
      peek_error <= next_peek_error;
      read_data <= next_read_data;
      state <= next_state;
      pend_step <= next_pend_step;
      pend_bit <= next_pend_bit;
      bit_value_q <= next_bit_value;
      bit_index_q <= next_bit_index;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      mem_we <= next_mem_we;
      mem_re <= next_mem_re;
      copy_req <= next_copy_req;
    end
  end

  // Pattern fetch address and cursor placement for the display path.
  always_comb begin
    next_cg_addr = {cg_offset, cg_char_code, cg_line};
    next_cg_from_rom = !cg_external && (cg_char_code <= CG_ROM_LAST);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cg_addr <= ADDR_RST;
      cg_from_rom <= 1'b0;
      cursor_column <= 7'h00;
      cursor_screen_row <= 4'h0;
      cursor_lower_half <= 1'b0;
    end else begin
      cg_addr <= next_cg_addr;
      cg_from_rom <= next_cg_from_rom;
      cursor_column <= cursor_col;
      cursor_screen_row <= cursor_row[3:0];
      cursor_lower_half <= dual_scan & cursor_row[4];
    end
  end

endmodule // lcd_command_decoder

/* File: inc/lcd_pkg.sv */
// Operation
// - C3 read-decrement, C4 write-hold, C5 read-hold
// - Bit op: bit3 set/reset, low three pick
// - Only 21H moves cursor column and row
// - Column keeps 7 bits, row 5 bits
// - Dual scan splits rows into two halves
// - 22H loads character generator offset
// - Pattern address: offset, code, line
// - Internal mode: codes 80H-FFH use RAM
// - 24H loads display RAM pointer
// - 40H text base, 41H text width
// - 42H graphic base, 43H graphic width
// - Text row start is base plus n*width
// - Graphic row start is base plus n*width
// - Shown columns come from configuration pins
// - Peek outside graphic area sets error
package lcd_pkg;

  // Register byte offsets.
  localparam logic [5:0] REG_OPERAND = 6'h00;
  localparam logic [5:0] REG_COMMAND = 6'h04;
  localparam logic [5:0] REG_STATUS = 6'h08;
  localparam logic [5:0] REG_READ_DATA = 6'h0C;
  localparam logic [5:0] REG_CURSOR = 6'h10;
  localparam logic [5:0] REG_CG_OFFSET = 6'h14;
  localparam logic [5:0] REG_POINTER = 6'h18;
  localparam logic [5:0] REG_TEXT_BASE = 6'h1C;
  localparam logic [5:0] REG_TEXT_WIDTH = 6'h20;
  localparam logic [5:0] REG_GFX_BASE = 6'h24;
  localparam logic [5:0] REG_GFX_WIDTH = 6'h28;
  localparam logic [5:0] REG_CONFIG = 6'h2C;

  // Field positions.
  localparam int CMD_READY_POS = 0;
  localparam int DATA_READY_POS = 1;
  localparam int PEEK_ERROR_POS = 6;
  localparam int CURSOR_ROW_POS = 8;
  localparam int CFG_DUAL_SCAN_POS = 0;
  localparam int CFG_EXT_CG_POS = 1;

  // Reset values.
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Sizes.
  localparam int COL_BITS = 7;
  localparam int ROW_BITS = 5;
  localparam int CG_OFFSET_BITS = 5;
  localparam logic [7:0] CG_ROM_LAST = 8'h7F;
  localparam logic [7:0] GFX_LINES = 8'h80;

  // Opcodes.
  localparam logic [7:0] OPC_CURSOR = 8'h21;
  localparam logic [7:0] OPC_OFFSET = 8'h22;
  localparam logic [7:0] OPC_POINTER = 8'h24;
  localparam logic [7:0] OPC_TEXT_BASE = 8'h40;
  localparam logic [7:0] OPC_TEXT_WIDTH = 8'h41;
  localparam logic [7:0] OPC_GFX_BASE = 8'h42;
  localparam logic [7:0] OPC_GFX_WIDTH = 8'h43;
  localparam logic [7:0] OPC_PEEK = 8'hE0;
  localparam logic [7:0] OPC_COPY = 8'hE8;

  typedef enum logic [1:0] {STEP_HOLD, STEP_INC, STEP_DEC} lcd_step_t;

  typedef enum {
    OP_NONE, OP_CURSOR, OP_OFFSET, OP_POINTER, OP_TEXT_BASE, OP_TEXT_WIDTH,
    OP_GFX_BASE, OP_GFX_WIDTH, OP_CG_MODE, OP_WRITE, OP_READ, OP_PEEK,
    OP_COPY, OP_BIT
  } lcd_op_t;

endpackage

/* File: verilog/lcd_op_decode.sv */
`timescale 1ns/1ps
module lcd_op_decode
  import lcd_pkg::*;
(
  input wire logic [7:0] opcode,
  output lcd_op_t op,
  output lcd_step_t step,
  output logic bit_value,
  output logic [2:0] bit_index,
  output logic cg_external
);

  always_comb begin
    op = OP_NONE;
    step = STEP_HOLD;
    bit_value = opcode[3];
    bit_index = opcode[2:0];
    cg_external = opcode[3];
    unique casez (opcode)
      OPC_CURSOR: op = OP_CURSOR;
      OPC_OFFSET: op = OP_OFFSET;
      OPC_POINTER: op = OP_POINTER;
      OPC_TEXT_BASE: op = OP_TEXT_BASE;
      OPC_TEXT_WIDTH: op = OP_TEXT_WIDTH;
      OPC_GFX_BASE: op = OP_GFX_BASE;
      OPC_GFX_WIDTH: op = OP_GFX_WIDTH;
      8'b1000_????: op = OP_CG_MODE;
      8'hC0: begin
        op = OP_WRITE;
        step = STEP_INC;
      end
      8'hC1: begin
        op = OP_READ;
        step = STEP_INC;
      end
      8'hC2: begin
        op = OP_WRITE;
        step = STEP_DEC;
      end
      8'hC3: begin
        op = OP_READ;
        step = STEP_DEC;
      end
      8'hC4: op = OP_WRITE;
      8'hC5: op = OP_READ;
      OPC_PEEK: op = OP_PEEK;
      OPC_COPY: op = OP_COPY;
      8'b1111_????: op = OP_BIT;
      default: op = OP_NONE;
    endcase
  end

endmodule // lcd_op_decode

/* File: verilog/lcd_row_addr.sv */
`timescale 1ns/1ps
module lcd_row_addr
  import lcd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] base,
  input wire logic [7:0] width,
  input wire logic [6:0] row_index,
  input wire logic [6:0] span,
  output logic [15:0] row_start,
  output logic [15:0] row_end
);

  logic [15:0] next_row_start;
  logic [15:0] next_row_end;
  logic [14:0] offset;

  always_comb begin
    offset = width * row_index;
    next_row_start = base + {1'b0, offset};
    next_row_end = next_row_start + {9'h000, span};
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      row_start <= ADDR_RST;
      row_end <= ADDR_RST;
    end else begin
      row_start <= next_row_start;
      row_end <= next_row_end;
    end
  end

endmodule // lcd_row_addr

/* File: verif/lcd_checker_properties.sv */
`timescale 1ns/1ps
module lcd_checker
  import lcd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic copy_req,
  input wire logic [6:0] pin_column_count,
  input wire logic [7:0] cg_char_code,
  input wire logic [2:0] cg_line,
  input wire logic [15:0] cg_addr,
  input wire logic cg_from_rom,
  input wire logic [15:0] text_row_start,
  input wire logic [15:0] text_row_end,
  input wire logic [15:0] graphic_row_start,
  input wire logic [15:0] graphic_row_end,
  input wire logic [6:0] cursor_column
);
  logic [3:0] since_cmd;
  logic [3:0] next_since_cmd;

  // Ages the last accepted command so cursor moves can be tied to one.
  always_comb begin
    next_since_cmd = since_cmd;
    if (avs_write && avs_address == REG_COMMAND && !avs_waitrequest) begin
      next_since_cmd = 4'h0;
    end else if (since_cmd != 4'hf) begin
      next_since_cmd = since_cmd + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      since_cmd <= 4'hf;
    end else begin
      since_cmd <= next_since_cmd;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  mem_excl_a: assert property (!(mem_we && mem_re))
    else $error("memory read and write together");
  we_pulse_a: assert property (mem_we |=> !mem_we)
    else $error("memory write pulse too long");
  cg_fields_a: assert property ($past(resetn) |->
    cg_addr[10:0] == {$past(cg_char_code), $past(cg_line)})
    else $error("pattern address low fields wrong");
  cg_rom_a: assert property (cg_from_rom |-> $past(cg_char_code) <= CG_ROM_LAST)
    else $error("high character code taken from rom");
  copy_pulse_a: assert property (copy_req |=> !copy_req)
    else $error("copy request too long");
  text_span_a: assert property ((resetn && $stable(pin_column_count))[*5] |->
    text_row_end == text_row_start + {9'h000, pin_column_count})
    else $error("text row span wrong");
  gfx_span_a: assert property ((resetn && $stable(pin_column_count))[*5] |->
    graphic_row_end == graphic_row_start + {9'h000, pin_column_count})
    else $error("graphic row span wrong");
  cursor_cause_a: assert property (!$stable(cursor_column) |-> since_cmd <= 4'h8)
    else $error("cursor moved without a command");

  cover property (mem_re ##3 1'b1);
  cover property (copy_req);
  cover property (!$stable(cursor_column));
endmodule // lcd_checker

bind lcd_command_decoder lcd_checker u_lcd_checker (.clk, .resetn, .avs_address, .avs_write,
  .avs_waitrequest, .mem_we, .mem_re, .copy_req, .pin_column_count, .cg_char_code, .cg_line,
  .cg_addr, .cg_from_rom, .text_row_start, .text_row_end, .graphic_row_start,
  .graphic_row_end, .cursor_column);

/* File: verif/lcd_ram_model.sv */
`timescale 1ns/1ps
module lcd_ram_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    mem_rdata = 8'h00;
  end

  // Read data is good for one cycle only; it inverts every cycle after, so a sample one cycle late never matches.
  always @(posedge clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_re) begin
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // lcd_ram_model

/* File: verif/test_lcd_command_decoder.sv */
`timescale 1ns/1ps
module test_lcd_command_decoder
  import lcd_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [3:0] avs_byteenable = 4'h1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_we;
  logic mem_re;
  logic [7:0] mem_rdata;
  logic copy_req;
  logic [6:0] pin_column_count = 7'h20;
  logic [7:0] cg_char_code = 8'h00;
  logic [2:0] cg_line = 3'h0;
  logic [15:0] cg_addr;
  logic cg_from_rom;
  logic [6:0] row_index = 7'h00;
  logic [15:0] text_row_start;
  logic [15:0] text_row_end;
  logic [15:0] graphic_row_start;
  logic [15:0] graphic_row_end;
  logic [6:0] cursor_column;
  logic [3:0] cursor_screen_row;
  logic cursor_lower_half;
  logic [31:0] rd;
  logic [7:0] b;
  int num_errors = 0;
  int samples_checked = 0;
  int copies = 0;

  lcd_command_decoder u_lcd_command_decoder (.clk, .resetn, .avs_address, .avs_byteenable,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_addr,
    .mem_wdata, .mem_we, .mem_re, .mem_rdata, .copy_req, .pin_column_count, .cg_char_code,
    .cg_line, .cg_addr, .cg_from_rom, .row_index, .text_row_start, .text_row_end,
    .graphic_row_start, .graphic_row_end, .cursor_column, .cursor_screen_row,
    .cursor_lower_half);
  lcd_ram_model u_lcd_ram_model (.clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (copy_req === 1'b1) begin
      copies++;
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      close_out();
    end
  endtask

  // Both ready bits must be seen before each register write, as the host is obliged to do.
  task automatic ready;
    int n;
    n = 0;
    do begin
      bus(1'b0, REG_STATUS, 8'h00);
      n++;
    end while (rd[1:0] !== 2'b11 && n < 50);
    if (rd[1:0] !== 2'b11) begin
      num_errors++;
    end
  endtask

  task automatic put(input logic [5:0] a, input logic [7:0] d);
    ready();
    bus(1'b1, a, d);
  endtask

  task automatic get(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask

  task automatic cmd0(input logic [7:0] op);
    put(REG_COMMAND, op);
    ready();
  endtask

  task automatic cmd(input logic [7:0] op, input logic [7:0] d1, input logic [7:0] d2);
    put(REG_OPERAND, d1);
    put(REG_OPERAND, d2);
    cmd0(op);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    get(REG_STATUS, 32'h0000_0003);
    get(REG_CURSOR, 32'h0000_0000);
    get(6'h3C, 32'h0000_0000);
    $display("test reset done");
    put(REG_CONFIG, 8'h01);
    cmd(OPC_CURSOR, 8'hCF, 8'hFF);
    get(REG_CURSOR, 32'h0000_1F4F);
    chk({cursor_lower_half, cursor_screen_row, cursor_column}, 32'h0000_0FCF);
    put(REG_CONFIG, 8'h00);
    repeat (3) @(posedge clk);
    chk(cursor_lower_half, 32'h0000_0000);
    avs_byteenable <= 4'h0;
    put(REG_CONFIG, 8'h03);
    avs_byteenable <= 4'h1;
    get(REG_CONFIG, 32'h0000_0000);
    $display("test cursor done");
    put(REG_OPERAND, 8'h11);
    cmd(OPC_POINTER, 8'h22, 8'h33);
    get(REG_POINTER, 32'h0000_3322);
    put(REG_OPERAND, 8'h5A);
    cmd0(8'hC4);
    chk(u_lcd_ram_model.mem[16'h3322], 32'h0000_005A);
    get(REG_POINTER, 32'h0000_3322);
    cmd0(8'hC5);
    get(REG_READ_DATA, 32'h0000_005A);
    get(REG_POINTER, 32'h0000_3322);
    cmd0(8'hC3);
    get(REG_READ_DATA, 32'h0000_005A);
    get(REG_POINTER, 32'h0000_3321);
    get(REG_CURSOR, 32'h0000_1F4F);
    $display("test data done");
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      cmd0(8'hF8 | 8'(i));
      b = b | (8'h01 << i);
      chk(u_lcd_ram_model.mem[16'h3321], {24'h00_0000, b});
    end
    cmd0(8'hF0);
    chk(u_lcd_ram_model.mem[16'h3321], 32'h0000_00FE);
    $display("test bits done");
    cmd(OPC_OFFSET, 8'h1F, 8'h00);
    get(REG_CG_OFFSET, 32'h0000_001F);
    cg_char_code <= 8'h80;
    cg_line <= 3'h5;
    repeat (2) @(posedge clk);
    chk({cg_from_rom, cg_addr}, 32'h0000_FC05);
    cg_char_code <= 8'h7F;
    repeat (2) @(posedge clk);
    chk({cg_from_rom, cg_addr}, 32'h0001_FBFD);
    cmd0(8'h8F);
    chk(cg_from_rom, 32'h0000_0000);
    cmd0(8'h87);
    chk(cg_from_rom, 32'h0000_0001);
    $display("test pattern done");
    cmd(OPC_TEXT_BASE, 8'h34, 8'h12);
    cmd(OPC_TEXT_WIDTH, 8'h28, 8'h00);
    cmd(OPC_GFX_BASE, 8'h00, 8'h02);
    cmd(OPC_GFX_WIDTH, 8'h10, 8'h00);
    get(REG_TEXT_BASE, 32'h0000_1234);
    get(REG_TEXT_WIDTH, 32'h0000_0028);
    get(REG_GFX_BASE, 32'h0000_0200);
    get(REG_GFX_WIDTH, 32'h0000_0010);
    row_index <= 7'h03;
    repeat (4) @(posedge clk);
    chk({text_row_start, text_row_end}, 32'h12AC_12CC);
    chk({graphic_row_start, graphic_row_end}, 32'h0230_0250);
    $display("test rows done");
    cmd(OPC_POINTER, 8'h00, 8'h01);
    cmd0(OPC_PEEK);
    get(REG_STATUS, 32'h0000_0043);
    cmd(OPC_POINTER, 8'h00, 8'h03);
    cmd0(OPC_PEEK);
    get(REG_STATUS, 32'h0000_0003);
    get(REG_READ_DATA, 32'h0000_0000);
    copies = 0;
    cmd0(OPC_COPY);
    chk(copies, 32'h0000_0001);
    put(REG_OPERAND, 8'hA5);
    cmd0(8'hC0);
    put(REG_OPERAND, 8'h3C);
    cmd0(8'hC2);
    cmd0(8'hC1);
    get(REG_READ_DATA, 32'h0000_00A5);
    get(REG_POINTER, 32'h0000_0301);
    chk(u_lcd_ram_model.mem[16'h0301], 32'h0000_003C);
    $display("test peek done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule // test_lcd_command_decoder
